// File: pkg/ctr_readout_cfg.svh
// constants for the counter readout block
`ifndef CTR_READOUT_CFG_SVH
`define CTR_READOUT_CFG_SVH
`define RD_NOWAIT 2'h1
`define RD_WAIT 2'h2
`define RD_SELF 2'h3
`define IE_NONE 2'h0
`define IE_DONE 2'h1
`define IE_OVF 2'h2
`define CAUSE_NONE 2'h0
`define CAUSE_DONE 2'h1
`define CAUSE_OVF 2'h3
`define FN_STOP 3'h0
`define FN_UP 3'h1
`define FN_DOWN 3'h2
`define FN_PULSE 3'h7
`define EDGE_RR 3'h1
`define COUNT_MAX 24'hF423F
`define LOCAL_DIGITS 4'h6
`define REMOTE_DIGITS 4'h7
`define PRESET_RST 24'h000000
`endif

// File: pkg/ctr_readout_pkg.sv
// types for the counter readout block
package ctr_readout_pkg;
  typedef enum logic [2:0] {
    RES_COUNT = 3'b000,
    RES_NOT_STARTED = 3'b001,
    RES_INTERIM = 3'b010,
    RES_COMPLETE = 3'b011,
    RES_OVERFLOW = 3'b100
  } res_kind_t;
  typedef struct packed {
    res_kind_t kind;
    logic negative;
    logic [23:0] value;
    logic [3:0] digits;
  } result_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SELF = 2'b10
  } rd_state_t;
endpackage

// File: logic/result_hold.sv
// holds the last completed timing result
module result_hold
  import ctr_readout_pkg::*;
#(
  parameter int W = 24
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic clear,
  input wire logic [W-1:0] din,
  output logic valid,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic v;
    logic [W-1:0] d;
  } hold_t;
  hold_t s_r;
  hold_t s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    if (clear)
      s_nxt.v = 1'b0;
    if (load)
    begin
      s_nxt.v = 1'b1;
      s_nxt.d = din;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign valid = s_r.v;
  assign dout = s_r.d;
endmodule

// File: logic/counter_readout.sv
// readout and interrupt logic of the event counter / timer
// Functional notes
// - read requests carry mode non-blocking, blocking or self-triggered
// - local results six digits, remote results seven digits
// - timing not started reads as negative sentinel, dashes locally
// - started but unfinished timing result carries negative sign
// - finished timing result carries positive sign
// - overflow gives positive sentinel remotely, overload locally
// - count totals readable any time without disturbing counting
// - non-blocking read samples state, interim values allowed
// - completed result repeats until next measurement begins
// - reset stops counter and selects rising to rising edges
// - blocking read in timing modes answers only when complete
// - no interim on blocking read; counting modes answer at once
// - self mode on parallel bus refreshes continuously
// - serial self mode follows output setting, single acts as blocking
// - commands during self mode wait for current measurement end; a measurement that ends in overflow does not release them
// - interrupt enable codes none, on complete, on overflow
// - high output port toggles on overflow or complete except pulse mode
// - interrupt conditions depend on function
// - cause query answers none, complete or overflow codes
// - reset disables interrupts, selects non-blocking read, clears preset
`include "ctr_readout_cfg.svh"
module counter_readout
  import ctr_readout_pkg::*;
#(
  parameter int W = 24
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic soft_reset,
  input wire logic [2:0] function_select,
  input wire logic cfg_valid,
  input wire logic [1:0] int_enable,
  input wire logic [23:0] preset_in,
  input wire logic preset_valid,
  input wire logic serial_link,
  input wire logic serial_single,
  input wire logic read_request,
  input wire logic [1:0] read_mode,
  input wire logic cmd_valid,
  input wire logic interrupt_cause_query,
  input wire logic meas_started,
  input wire logic meas_done,
  input wire logic meas_overflow,
  input wire logic [W-1:0] meas_value,
  input wire logic [W-1:0] count_value,
  input wire logic count_overflow,
  input wire logic count_zero,
  output logic cmd_ready,
  output logic result_valid,
  output result_t remote_result,
  output result_t local_result,
  output logic overload_indication,
  output logic total_count_indication,
  output logic high_output_port,
  output logic interrupt_req,
  output logic [1:0] cause_code,
  output logic [2:0] function_cur,
  output logic [2:0] edge_cur,
  output logic [1:0] read_mode_cur,
  output logic [1:0] int_enable_cur,
  output logic [23:0] preset_cur,
  output logic meas_start_req
);
  typedef struct packed {
    rd_state_t st;
    logic [2:0] fn;
    logic [2:0] edge_sel;
    logic [1:0] rmode;
    logic [1:0] ie;
    logic [23:0] preset;
    logic started;
    logic ovf;
    logic hi;
    logic irq;
    logic [1:0] cause;
    logic rv;
    result_t rem;
    result_t loc;
    logic [1:0] cq;
    logic start;
  } state_t;
  state_t s_r;
  state_t s_nxt;
  logic held_valid;
  logic [W-1:0] held_value;
  logic timing;
  logic done_ev;
  logic ovf_ev;
  logic busy;

  function automatic logic is_timing(input logic [2:0] f);
    is_timing = (f != `FN_STOP) && (f != `FN_UP) && (f != `FN_DOWN) && (f != `FN_PULSE);
  endfunction

  function automatic result_t mk(input res_kind_t k, input logic neg,
                                 input logic [23:0] v, input logic [3:0] d);
    mk.kind = k;
    mk.negative = neg;
    mk.value = v;
    mk.digits = d;
  endfunction

  assign timing = is_timing(s_r.fn);
  // conditions per function
  assign done_ev = timing ? meas_done : (s_r.fn == `FN_DOWN && count_zero);
  assign ovf_ev = timing ? meas_overflow : (s_r.fn == `FN_UP && count_overflow);
  // self mode holds new commands until a running measurement completes without overflow
  assign busy = (s_r.st == ST_SELF) && timing && s_r.started && !done_ev;

  result_hold #(.W(W)) u_hold (
    .clk(clk),
    .arst_n(arst_n),
    .load(timing && meas_done && !meas_overflow),
    .clear(timing && meas_started),
    .din(meas_value),
    .valid(held_valid),
    .dout(held_value)
  );

  // builds the remote and local answers for the current state
  function automatic void answer(output result_t rr, output result_t lr);
    if (s_r.ovf)
    begin
      rr = mk(RES_OVERFLOW, 1'b0, '0, `REMOTE_DIGITS);
      lr = mk(RES_OVERFLOW, 1'b0, '0, `LOCAL_DIGITS);
    end
    else if (!timing)
    begin
      rr = mk(RES_COUNT, 1'b0, count_value, `REMOTE_DIGITS);
      lr = mk(RES_COUNT, 1'b0, count_value, `LOCAL_DIGITS);
    end
    else if (held_valid && !s_r.started)
    begin
      rr = mk(RES_COMPLETE, 1'b0, held_value, `REMOTE_DIGITS);
      lr = mk(RES_COMPLETE, 1'b0, held_value, `LOCAL_DIGITS);
    end
    else if (s_r.started)
    begin
      rr = mk(RES_INTERIM, 1'b1, meas_value, `REMOTE_DIGITS);
      lr = mk(RES_INTERIM, 1'b1, meas_value, `LOCAL_DIGITS);
    end
    else
    begin
      rr = mk(RES_NOT_STARTED, 1'b1, '0, `REMOTE_DIGITS);
      lr = mk(RES_NOT_STARTED, 1'b1, '0, `LOCAL_DIGITS);
    end
  endfunction

  always_comb
  begin
    result_t rr;
    result_t lr;
    rr = '0;
    lr = '0;
    s_nxt = s_r;
    s_nxt.rv = 1'b0;
    s_nxt.start = 1'b0;
    if (timing && meas_started)
      s_nxt.started = 1'b1;
    if (timing && meas_done)
      s_nxt.started = 1'b0;
    if (ovf_ev)
      s_nxt.ovf = 1'b1;
    if (cfg_valid && !busy)
    begin
      s_nxt.fn = function_select;
      s_nxt.ie = int_enable;
      s_nxt.started = 1'b0;
      s_nxt.ovf = 1'b0;
      s_nxt.st = ST_IDLE;
    end
    if (preset_valid && !busy)
      s_nxt.preset = preset_in;
    // level change on complete or overflow, not in pulse output mode
    if ((done_ev || ovf_ev) && s_r.fn != `FN_PULSE)
      s_nxt.hi = ~s_r.hi;
    if (done_ev && s_r.ie == `IE_DONE)
    begin
      s_nxt.irq = 1'b1;
      s_nxt.cause = `CAUSE_DONE;
    end
    if (ovf_ev && s_r.ie == `IE_OVF)
    begin
      s_nxt.irq = 1'b1;
      s_nxt.cause = `CAUSE_OVF;
    end
    if (interrupt_cause_query)
    begin
      s_nxt.cq = s_r.irq ? s_r.cause : `CAUSE_NONE;
      if (!(done_ev || ovf_ev))
      begin
        s_nxt.irq = 1'b0;
        s_nxt.cause = `CAUSE_NONE;
      end
    end
    answer(rr, lr);
    case (s_r.st)
      ST_IDLE:
      begin
        if (read_request && cmd_valid)
        begin
          s_nxt.rmode = read_mode;
          case (read_mode)
            `RD_NOWAIT:
            begin
              s_nxt.rv = 1'b1;
              s_nxt.rem = rr;
              s_nxt.loc = lr;
            end
            `RD_WAIT:
            begin
              if (!timing || s_r.ovf || (held_valid && !s_r.started))
              begin
                s_nxt.rv = 1'b1;
                s_nxt.rem = rr;
                s_nxt.loc = lr;
              end
              else
              begin
                s_nxt.st = ST_WAIT;
                s_nxt.loc = lr;
              end
            end
            `RD_SELF:
            begin
              s_nxt.start = timing;
              s_nxt.st = (serial_link && serial_single) ? ST_WAIT : ST_SELF;
            end
            default:
            begin
              s_nxt.rmode = s_r.rmode;
            end
          endcase
        end
      end
      ST_WAIT:
      begin
        s_nxt.loc = lr;
        if (!timing || s_r.ovf || ovf_ev || done_ev)
        begin
          s_nxt.rv = 1'b1;
          s_nxt.rem = ovf_ev ? mk(RES_OVERFLOW, 1'b0, '0, `REMOTE_DIGITS)
            : (done_ev ? mk(RES_COMPLETE, 1'b0, meas_value, `REMOTE_DIGITS) : rr);
          s_nxt.loc = s_nxt.rem;
          s_nxt.loc.digits = `LOCAL_DIGITS;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_SELF:
      begin
        // continuous update cycles
        if (!timing)
        begin
          s_nxt.rv = 1'b1;
          s_nxt.rem = rr;
          s_nxt.loc = lr;
        end
        else if (done_ev || ovf_ev)
        begin
          s_nxt.rv = 1'b1;
          s_nxt.rem = ovf_ev ? mk(RES_OVERFLOW, 1'b0, '0, `REMOTE_DIGITS)
            : mk(RES_COMPLETE, 1'b0, meas_value, `REMOTE_DIGITS);
          s_nxt.loc = s_nxt.rem;
          s_nxt.loc.digits = `LOCAL_DIGITS;
          s_nxt.start = 1'b1;
        end
        if (read_request && cmd_valid && !busy && read_mode != `RD_SELF)
          s_nxt.st = ST_IDLE;
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (soft_reset)
    begin
      s_nxt = '0;
      s_nxt.fn = `FN_STOP;
      s_nxt.edge_sel = `EDGE_RR;
      s_nxt.rmode = `RD_NOWAIT;
      s_nxt.ie = `IE_NONE;
      s_nxt.preset = `PRESET_RST;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
      s_r.fn <= `FN_STOP;
      s_r.edge_sel <= `EDGE_RR;
      s_r.rmode <= `RD_NOWAIT;
      s_r.ie <= `IE_NONE;
      s_r.preset <= `PRESET_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign cmd_ready = !busy && (s_r.st != ST_WAIT);
  assign result_valid = s_r.rv;
  assign remote_result = s_r.rem;
  assign local_result = s_r.loc;
  assign overload_indication = s_r.loc.kind == RES_OVERFLOW;
  assign total_count_indication = s_r.loc.kind == RES_COUNT;
  assign high_output_port = s_r.hi;
  assign interrupt_req = s_r.irq;
  assign cause_code = s_r.cq;
  assign function_cur = s_r.fn;
  assign edge_cur = s_r.edge_sel;
  assign read_mode_cur = s_r.rmode;
  assign int_enable_cur = s_r.ie;
  assign preset_cur = s_r.preset;
  assign meas_start_req = s_r.start;

  property p_wait_no_interim;
    @(posedge clk) disable iff (!arst_n)
      (s_r.st == ST_WAIT && timing) |-> !(result_valid && remote_result.kind == RES_INTERIM);
  endproperty
  a_wait_no_interim: assert property (p_wait_no_interim) else $error("interim on wait");

  property p_done_positive;
    @(posedge clk) disable iff (!arst_n)
      (result_valid && remote_result.kind == RES_COMPLETE) |-> !remote_result.negative;
  endproperty
  a_done_positive: assert property (p_done_positive) else $error("complete not positive");

  property p_interim_negative;
    @(posedge clk) disable iff (!arst_n)
      (result_valid && remote_result.kind == RES_INTERIM) |-> remote_result.negative;
  endproperty
  a_interim_negative: assert property (p_interim_negative) else $error("interim sign");

  property p_hi_toggle;
    @(posedge clk) disable iff (!arst_n || soft_reset)
      ((done_ev || ovf_ev) && s_r.fn != `FN_PULSE) |=> high_output_port != $past(high_output_port);
  endproperty
  a_hi_toggle: assert property (p_hi_toggle) else $error("no level change");

  property p_irq_ovf;
    @(posedge clk) disable iff (!arst_n || soft_reset)
      (ovf_ev && s_r.ie == `IE_OVF) |=> interrupt_req;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("no overflow irq");

  property p_no_irq_disabled;
    @(posedge clk) disable iff (!arst_n)
      (s_r.ie == `IE_NONE && !interrupt_req) |=> !interrupt_req || $past(cfg_valid);
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while off");

  property p_reset_defaults;
    @(posedge clk) disable iff (!arst_n)
      soft_reset |=> (function_cur == `FN_STOP && int_enable_cur == `IE_NONE
        && read_mode_cur == `RD_NOWAIT && preset_cur == `PRESET_RST);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults");

  property p_digits;
    @(posedge clk) disable iff (!arst_n)
      result_valid |-> remote_result.digits == `REMOTE_DIGITS;
  endproperty
  a_digits: assert property (p_digits) else $error("remote digits");
endmodule

// File: testbench/meas_core_model.sv
// measurement core model feeding start, done, overflow and counts
module meas_core_model
  import ctr_readout_pkg::*;
#(
  parameter int LEN = 12
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic ovf,
  output logic meas_started,
  output logic meas_done,
  output logic meas_overflow,
  output logic [23:0] meas_value,
  output logic [23:0] count_value
);
  timeunit 1ns;
  timeprecision 100ps;
  int ph;
  int cnt;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph <= 0;
      cnt <= 0;
      meas_started <= 1'b0;
      meas_done <= 1'b0;
      meas_overflow <= 1'b0;
      meas_value <= 24'h000000;
      count_value <= 24'h000000;
    end
    else
    begin
      meas_started <= 1'b0;
      meas_done <= 1'b0;
      meas_overflow <= 1'b0;
      count_value <= count_value + 24'h000001;
      cnt <= cnt + 1;
      if (ph == 0 && go)
      begin
        ph <= 1;
        cnt <= 0;
      end
      else if (ph == 1 && cnt == 2)
      begin
        ph <= 2;
        cnt <= 0;
        meas_value <= 24'h000000;
        meas_started <= 1'b1;
      end
      else if (ph == 2)
      begin
        meas_value <= meas_value + 24'h000003;
        if (cnt == LEN)
        begin
          ph <= 0;
          meas_done <= !ovf;
          meas_overflow <= ovf;
        end
      end
    end
  end
endmodule

// File: testbench/counter_readout_tb.sv
// self-checking bench for the counter readout block
`include "ctr_readout_cfg.svh"
module counter_readout_tb
  import ctr_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LEN = 12;
  logic clk, arst_n, soft_reset, cfg_valid, preset_valid, serial_link, serial_single;
  logic read_request, cmd_valid, interrupt_cause_query, meas_started, meas_done;
  logic meas_overflow, count_overflow, count_zero, cmd_ready, result_valid;
  logic overload_indication, total_count_indication, high_output_port, interrupt_req;
  logic meas_start_req, go_tb, ovf, hi_prev;
  logic [2:0] function_select, function_cur, edge_cur;
  logic [1:0] int_enable, read_mode, cause_code, read_mode_cur, int_enable_cur;
  logic [23:0] preset_in, preset_cur, meas_value, count_value, exp_val;
  result_t remote_result, local_result;
  int num_errors = 0;
  int samples_checked = 0;
  int fn, st, wmode;
  counter_readout #(.W(24)) counter_readout_i (.clk, .arst_n, .soft_reset, .function_select,
    .cfg_valid, .int_enable, .preset_in, .preset_valid, .serial_link, .serial_single,
    .read_request, .read_mode, .cmd_valid, .interrupt_cause_query, .meas_started,
    .meas_done, .meas_overflow, .meas_value, .count_value, .count_overflow, .count_zero,
    .cmd_ready, .result_valid, .remote_result, .local_result, .overload_indication,
    .total_count_indication, .high_output_port, .interrupt_req, .cause_code,
    .function_cur, .edge_cur, .read_mode_cur, .int_enable_cur, .preset_cur,
    .meas_start_req);
  meas_core_model #(.LEN(LEN)) meas_core_model_i (.clk, .arst_n, .go(go_tb | meas_start_req),
    .ovf, .meas_started, .meas_done, .meas_overflow, .meas_value, .count_value);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    results();
  end
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // reference model of the reported result kind
  function automatic int exp_kind();
    if (fn < 3)
      return (st == 3) ? RES_OVERFLOW : RES_COUNT;
    case (st)
      0: return RES_NOT_STARTED;
      1: return RES_INTERIM;
      2: return RES_COMPLETE;
      default: return RES_OVERFLOW;
    endcase
  endfunction
  task automatic take();
    int n;
    int k;
    logic done_seen;
    n = 0;
    done_seen = 1'b0;
    while (result_valid !== 1'b1 && n < 300)
    begin
      cyc();
      n++;
      done_seen = done_seen | (meas_done === 1'b1);
    end
    k = exp_kind();
    chk("timeout", 0, n == 300);
    chk("kind", k, remote_result.kind);
    chk("negative", k == RES_NOT_STARTED || k == RES_INTERIM, remote_result.negative);
    chk("remote_digits", `REMOTE_DIGITS, remote_result.digits);
    chk("local_digits", `LOCAL_DIGITS, local_result.digits);
    chk("overload", k == RES_OVERFLOW, overload_indication);
    chk("total", k == RES_COUNT, total_count_indication);
    if (k == RES_COUNT)
      chk("count", exp_val, remote_result.value);
    if (k == RES_COMPLETE)
      chk("time", 3 * (LEN + 1), remote_result.value);
    if (k == RES_COMPLETE && wmode)
      chk("early", 1, done_seen);
  endtask
  task automatic rd(input logic [1:0] m);
    read_request = 1'b1;
    cmd_valid = 1'b1;
    read_mode = m;
    exp_val = count_value;
    wmode = (m != `RD_NOWAIT);
    cyc();
    read_request = 1'b0;
    cmd_valid = 1'b0;
    take();
    cyc();
  endtask
  task automatic cfg(input logic [2:0] f, input logic [1:0] ie);
    function_select = f;
    int_enable = ie;
    cfg_valid = 1'b1;
    cyc();
    cfg_valid = 1'b0;
    cyc();
    fn = f;
    st = 0;
    chk("function", f, function_cur);
    chk("int_enable", ie, int_enable_cur);
  endtask
  task automatic query(input logic [1:0] ec);
    interrupt_cause_query = 1'b1;
    cyc();
    interrupt_cause_query = 1'b0;
    cyc();
    chk("irq_clear", 0, interrupt_req);
    chk("cause", ec, cause_code);
  endtask
  task automatic defaults();
    chk("function", `FN_STOP, function_cur);
    chk("edge", `EDGE_RR, edge_cur);
    chk("read_mode", `RD_NOWAIT, read_mode_cur);
    chk("int_enable", `IE_NONE, int_enable_cur);
    chk("preset", `PRESET_RST, preset_cur);
  endtask
  initial
  begin
    {arst_n, soft_reset, cfg_valid, preset_valid, serial_link, serial_single} = 6'h00;
    {read_request, cmd_valid, interrupt_cause_query, count_overflow, count_zero} = 5'h00;
    {go_tb, ovf, function_select, int_enable, read_mode} = 9'h000;
    preset_in = 24'h000000;
    void'($urandom(25696));
    cyc(6);
    arst_n = 1'b1;
    cyc();
    defaults();
    preset_in = 24'($urandom % 1000000);
    preset_valid = 1'b1;
    cyc();
    preset_valid = 1'b0;
    cyc();
    chk("preset", preset_in, preset_cur);
    soft_reset = 1'b1;
    cyc();
    soft_reset = 1'b0;
    cyc();
    defaults();
    $display("test reset done");
    cfg(`FN_UP, `IE_NONE);
    rd(`RD_NOWAIT);
    rd(`RD_WAIT);
    repeat (4) rd(2'($urandom % 2 + 1));
    $display("test count read done");
    for (int i = 0; i < 3; i++)
    begin
      cfg(i == 0 ? `FN_DOWN : `FN_UP, i == 0 ? `IE_DONE : (i == 1 ? `IE_NONE : `IE_OVF));
      hi_prev = high_output_port;
      count_zero = (i == 0);
      count_overflow = (i != 0);
      cyc();
      count_zero = 1'b0;
      count_overflow = 1'b0;
      cyc(2);
      chk("irq", i != 1, interrupt_req);
      chk("high_port", !hi_prev, high_output_port);
      st = (i != 0) ? 3 : 0;
      rd(`RD_NOWAIT);
      query(i == 0 ? `CAUSE_DONE : (i == 1 ? `CAUSE_NONE : `CAUSE_OVF));
    end
    $display("test interrupts done");
    cfg(3'h5, `IE_DONE);
    rd(`RD_NOWAIT);
    go_tb = 1'b1;
    cyc();
    go_tb = 1'b0;
    cyc(5);
    st = 1;
    rd(`RD_NOWAIT);
    while (meas_done !== 1'b1)
      cyc();
    cyc(2);
    st = 2;
    chk("irq", 1, interrupt_req);
    rd(`RD_NOWAIT);
    rd(`RD_NOWAIT);
    query(`CAUSE_DONE);
    $display("test nonblocking timing done");
    go_tb = 1'b1;
    cyc();
    go_tb = 1'b0;
    cyc(5);
    rd(`RD_WAIT);
    ovf = 1'b1;
    st = 3;
    go_tb = 1'b1;
    cyc();
    go_tb = 1'b0;
    cyc(5);
    rd(`RD_WAIT);
    ovf = 1'b0;
    $display("test blocking timing done");
    cfg(3'h5, `IE_NONE);
    st = 2;
    rd(`RD_SELF);
    cyc(5);
    chk("cmd_ready", 0, cmd_ready);
    take();
    $display("test self trigger done");
    results();
  end
endmodule
